// [core/fault_reset_timer.sv]
// Qualifies the held motor fault reset request
`timescale 1ns/1ns
`default_nettype none
module fault_reset_timer #(
  parameter int unsigned HOLD_CYCLES = zone_cmd_pkg::HOLD_CYCLES_DEF
) (
  input wire logic clk_i,     // System clock
  input wire logic rst_i,     // Synchronous reset
  input wire logic hold_i,    // Reset request bit level
  output logic accept_o       // One pulse per accepted hold
);
  import zone_cmd_pkg::*;

  hold_state_t state_q;
  logic [31:0] cnt_q;
  logic at_end;

  assign at_end = (cnt_q == 32'(HOLD_CYCLES - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= HOLD_IDLE;
    end else begin
      unique case (state_q)
        HOLD_IDLE: if (hold_i) state_q <= HOLD_COUNT;
        HOLD_COUNT: begin
          if (!hold_i) begin
            state_q <= HOLD_IDLE;
          end else if (at_end) begin
            state_q <= HOLD_DONE;
          end
        end
        HOLD_DONE: if (!hold_i) state_q <= HOLD_IDLE;
        default: state_q <= HOLD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != HOLD_COUNT) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  // A long hold gives one reset, not a stream of them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      accept_o <= 1'b0;
    end else begin
      accept_o <= (state_q == HOLD_COUNT) && hold_i && at_end;
    end
  end
endmodule
`default_nettype wire

// [core/release_detect.sv]
// Zone release register with change detection
`timescale 1ns/1ns
`default_nettype none
module release_detect (
  input wire logic clk_i,  // System clock
  input wire logic rst_i,  // Synchronous reset
  zone_rel_if.zone rel     // Write side and event
);
  import zone_cmd_pkg::*;

  logic [15:0] value_q;
  logic evt_q;

  assign rel.value = value_q;
  assign rel.release_evt = evt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      value_q <= REG_RST;
    end else if (rel.wr) begin
      value_q <= rel.wdata;
    end
  end

  // Same value rewritten by the cyclic image makes no event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_q <= 1'b0;
    end else begin
      evt_q <= rel.wr && rel.accum_en && (rel.wdata != value_q);
    end
  end
endmodule
`default_nettype wire

// [core/zone_cmd_regs.sv]
// Zone release, status handshake, tracking, fault reset and aux registers
//
// Overview of operation
// - Release value change releases and rearms zone
// - Accumulation control bit zero enables release
// - Upstream status four runs zone to accept
// - Upstream status one loads induct tracking
// - Downstream status five holds arriving carton
// - Downstream status one permits carton release
// - Forward words give tracking in default direction
// - Reverse words give tracking in reverse direction
// - Fault reset bit: one asserts, zero withdraws
// - Fatal faults latch until accepted reset
// - Bits 8, 9 set aux pin direction
// - Bits 12, 13 drive levels when output
// - Other aux bits are reserved, no effect
// - Aux control only when pin usage unassigned
`timescale 1ns/1ns
`default_nettype none
module zone_cmd_regs #(
  parameter int unsigned HOLD_CYCLES = zone_cmd_pkg::HOLD_CYCLES_DEF
) (
  input wire logic clk_i,                 // System clock, 100 MHz
  input wire logic rst_i,                 // Synchronous reset, high
  input wire logic wr_en_i,               // Register write strobe
  input wire logic [7:0] wr_addr_i,       // Register write offset
  input wire logic [15:0] wr_data_i,      // Register write data
  input wire logic [7:0] rd_addr_i,       // Register read offset
  output logic [15:0] rd_data_o,          // Read data, one cycle late
  input wire logic rev_dir_i,             // Conveyor runs reversed
  input wire logic [1:0] short_fault_i,   // Motor short, per motor
  input wire logic [1:0] sensor_fault_i,  // Rotor sensor fault
  input wire logic [1:0] aux_unassigned_i, // Aux usage is none
  input wire logic [1:0] aux_pin_i,       // Aux pin level, async
  output logic [1:0] aux_pin_o,           // Aux pin drive level
  output logic [1:0] aux_pin_oe_n_o,      // Aux drive enable, low
  output logic [1:0] aux_level_o,         // Synchronised aux level
  output logic up_release_o,              // Upstream release pulse
  output logic dn_release_o,              // Downstream release pulse
  output logic up_run_accept_o,           // Upstream run to accept
  output logic up_track_valid_o,          // Induct tracking loaded
  output logic [15:0] up_track_w1_o,      // Induct tracking word 1
  output logic [15:0] up_track_w2_o,      // Induct tracking word 2
  output logic dn_hold_o,                 // Downstream hold arrival
  output logic dn_release_ok_o,           // Downstream may release
  output logic [1:0] motor_fault_o,       // Latched fatal fault
  output logic fault_reset_o              // Accepted reset pulse
);
  import zone_cmd_pkg::*;

  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] off);
    hit = (addr == off);
  endfunction

  logic [15:0] fault_rst_q;
  logic [15:0] aux_q;
  logic [15:0] up_acc_q;
  logic [15:0] dn_acc_q;
  logic [15:0] up_stat_q;
  logic [15:0] dn_stat_q;
  logic [15:0] fwd1_q;
  logic [15:0] fwd2_q;
  logic [15:0] rev1_q;
  logic [15:0] rev2_q;
  logic [1:0] aux_meta_q;
  logic [1:0] aux_sync_q;
  logic [1:0] fault_q;
  logic accept;
  logic [15:0] rd_d;

  zone_rel_if up_rel ();
  zone_rel_if dn_rel ();

  // Release registers and their change detectors
  assign up_rel.wr = wr_en_i && hit(wr_addr_i, OFF_UP_REL);
  assign up_rel.wdata = wr_data_i;
  assign up_rel.accum_en = up_acc_q[ACC_MODE_BIT];
  assign dn_rel.wr = wr_en_i && hit(wr_addr_i, OFF_DN_REL);
  assign dn_rel.wdata = wr_data_i;
  assign dn_rel.accum_en = dn_acc_q[ACC_MODE_BIT];

  release_detect up_det (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rel(up_rel.zone)
  );

  release_detect dn_det (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rel(dn_rel.zone)
  );

  // One pulse both frees the carton and arms accumulation again
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_release_o <= 1'b0;
      dn_release_o <= 1'b0;
    end else begin
      up_release_o <= up_rel.release_evt;
      dn_release_o <= dn_rel.release_evt;
    end
  end

  // Accumulation control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_acc_q <= REG_RST;
      dn_acc_q <= REG_RST;
    end else if (wr_en_i) begin
      if (hit(wr_addr_i, OFF_UP_ACC)) up_acc_q <= wr_data_i;
      if (hit(wr_addr_i, OFF_DN_ACC)) dn_acc_q <= wr_data_i;
    end
  end

  // Foreign conveyor handshake status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_stat_q <= REG_RST;
      dn_stat_q <= REG_RST;
    end else if (wr_en_i) begin
      if (hit(wr_addr_i, OFF_UP_STAT)) up_stat_q <= wr_data_i;
      if (hit(wr_addr_i, OFF_DN_STAT)) dn_stat_q <= wr_data_i;
    end
  end

  // Other values leave the zones under their own logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_run_accept_o <= 1'b0;
      dn_hold_o <= 1'b0;
      dn_release_ok_o <= 1'b0;
    end else begin
      up_run_accept_o <= (up_stat_q == UP_STAT_ACCEPT);
      dn_hold_o <= (dn_stat_q == DN_STAT_HOLD);
      dn_release_ok_o <= (dn_stat_q == DN_STAT_RELEASE);
    end
  end

  // Induct tracking words
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fwd1_q <= REG_RST;
      fwd2_q <= REG_RST;
      rev1_q <= REG_RST;
      rev2_q <= REG_RST;
    end else if (wr_en_i) begin
      if (hit(wr_addr_i, OFF_FWD1)) fwd1_q <= wr_data_i;
      if (hit(wr_addr_i, OFF_FWD2)) fwd2_q <= wr_data_i;
      if (hit(wr_addr_i, OFF_REV1)) rev1_q <= wr_data_i;
      if (hit(wr_addr_i, OFF_REV2)) rev2_q <= wr_data_i;
    end
  end

  // Words follow direction while status holds; last taken words stay
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_track_valid_o <= 1'b0;
      up_track_w1_o <= REG_RST;
      up_track_w2_o <= REG_RST;
    end else if (up_stat_q == UP_STAT_TRACK) begin
      up_track_valid_o <= 1'b1;
      if (rev_dir_i) begin
        up_track_w1_o <= rev1_q;
        up_track_w2_o <= rev2_q;
      end else begin
        up_track_w1_o <= fwd1_q;
        up_track_w2_o <= fwd2_q;
      end
    end else begin
      up_track_valid_o <= 1'b0;
    end
  end

  // Motor fault reset request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_rst_q <= REG_RST;
    end else if (wr_en_i && hit(wr_addr_i, OFF_FAULT_RST)) begin
      fault_rst_q <= wr_data_i;
    end
  end

  fault_reset_timer #(
    .HOLD_CYCLES(HOLD_CYCLES)
  ) rst_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .hold_i(fault_rst_q[FAULT_RST_BIT]),
    .accept_o(accept)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_reset_o <= 1'b0;
    end else begin
      fault_reset_o <= accept;
    end
  end

  // New fault in the reset cycle survives the reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_q <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (short_fault_i[i] || sensor_fault_i[i]) begin
          fault_q[i] <= 1'b1;
        end else if (accept) begin
          fault_q[i] <= 1'b0;
        end
      end
    end
  end

  assign motor_fault_o = fault_q;

  // Aux pin control; reserved bits are stored but never used
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_q <= REG_RST;
    end else if (wr_en_i && hit(wr_addr_i, OFF_AUX)) begin
      aux_q <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_pin_o <= 2'b00;
      aux_pin_oe_n_o <= 2'b11;
    end else begin
      // Pin owned by another usage stays released
      if (aux_unassigned_i[0] && aux_q[AUX_L_DIR_BIT]) begin
        aux_pin_oe_n_o[0] <= 1'b0;
        aux_pin_o[0] <= aux_q[AUX_L_LVL_BIT];
      end else begin
        aux_pin_oe_n_o[0] <= 1'b1;
        aux_pin_o[0] <= 1'b0;
      end
      if (aux_unassigned_i[1] && aux_q[AUX_R_DIR_BIT]) begin
        aux_pin_oe_n_o[1] <= 1'b0;
        aux_pin_o[1] <= aux_q[AUX_R_LVL_BIT];
      end else begin
        aux_pin_oe_n_o[1] <= 1'b1;
        aux_pin_o[1] <= 1'b0;
      end
    end
  end

  // Pin level is asynchronous to the clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_meta_q <= 2'b00;
      aux_sync_q <= 2'b00;
    end else begin
      aux_meta_q <= aux_pin_i;
      aux_sync_q <= aux_meta_q;
    end
  end

  assign aux_level_o = aux_sync_q;

  // Read back; unmapped offsets read zero
  always_comb begin
    rd_d = REG_RST;
    unique case (rd_addr_i)
      OFF_FAULT_RST: begin
        rd_d = fault_rst_q;
        rd_d[RD_FAULT_LSB +: 2] = fault_q;
      end
      OFF_AUX: begin
        rd_d = aux_q;
        rd_d[RD_AUX_PIN_LSB +: 2] = aux_sync_q;
      end
      OFF_UP_ACC: rd_d = up_acc_q;
      OFF_UP_REL: rd_d = up_rel.value;
      OFF_UP_STAT: rd_d = up_stat_q;
      OFF_FWD1: rd_d = fwd1_q;
      OFF_FWD2: rd_d = fwd2_q;
      OFF_DN_ACC: rd_d = dn_acc_q;
      OFF_DN_REL: rd_d = dn_rel.value;
      OFF_DN_STAT: rd_d = dn_stat_q;
      OFF_REV1: rd_d = rev1_q;
      OFF_REV2: rd_d = rev2_q;
      default: rd_d = REG_RST;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o <= REG_RST;
    end else begin
      rd_data_o <= rd_d;
    end
  end
endmodule
`default_nettype wire

// [inc/zone_cmd_pkg.sv]
// Constants and types shared by the zone command register block
package zone_cmd_pkg;
  localparam int AW = 8;
  localparam int DW = 16;

  // Register offsets
  localparam logic [7:0] OFF_FAULT_RST = 8'h16;
  localparam logic [7:0] OFF_AUX = 8'h3F;
  localparam logic [7:0] OFF_UP_ACC = 8'h68;
  localparam logic [7:0] OFF_UP_REL = 8'h69;
  localparam logic [7:0] OFF_UP_STAT = 8'h86;
  localparam logic [7:0] OFF_FWD1 = 8'h8B;
  localparam logic [7:0] OFF_FWD2 = 8'h8C;
  localparam logic [7:0] OFF_DN_ACC = 8'hB8;
  localparam logic [7:0] OFF_DN_REL = 8'hB9;
  localparam logic [7:0] OFF_DN_STAT = 8'hE8;
  localparam logic [7:0] OFF_REV1 = 8'hED;
  localparam logic [7:0] OFF_REV2 = 8'hEE;

  // Field positions
  localparam int ACC_MODE_BIT = 0;
  localparam int FAULT_RST_BIT = 0;
  localparam int AUX_L_DIR_BIT = 8;
  localparam int AUX_R_DIR_BIT = 9;
  localparam int AUX_L_LVL_BIT = 12;
  localparam int AUX_R_LVL_BIT = 13;
  localparam int RD_AUX_PIN_LSB = 0;
  localparam int RD_FAULT_LSB = 8;

  // Status handshake values
  localparam logic [15:0] UP_STAT_ACCEPT = 16'h0004;
  localparam logic [15:0] UP_STAT_TRACK = 16'h0001;
  localparam logic [15:0] DN_STAT_HOLD = 16'h0005;
  localparam logic [15:0] DN_STAT_RELEASE = 16'h0001;

  localparam logic [15:0] REG_RST = 16'h0000;

  // Fault reset hold time
  localparam int unsigned HOLD_MS = 500;
  localparam int unsigned CLK_KHZ = 100000;
  localparam int unsigned HOLD_CYCLES_DEF = HOLD_MS * CLK_KHZ;

  typedef enum logic [2:0] {
    HOLD_IDLE = 3'b001,
    HOLD_COUNT = 3'b010,
    HOLD_DONE = 3'b100
  } hold_state_t;
endpackage

// [inc/zone_rel_if.sv]
// Carrier between the register core and one zone release detector
`timescale 1ns/1ns
`default_nettype none
interface zone_rel_if;
  logic wr;
  logic [15:0] wdata;
  logic accum_en;
  logic [15:0] value;
  logic release_evt;

  modport core (output wr, output wdata, output accum_en,
                input value, input release_evt);
  modport zone (input wr, input wdata, input accum_en,
                output value, output release_evt);
endinterface
`default_nettype wire

// [tb/plc_model.sv]
// Supervising controller model driving the register write port
`timescale 1ns/1ns
`default_nettype none
module plc_model (
  input wire logic clk_i,            // System clock
  output logic wr_en_o,              // Write strobe
  output logic [7:0] wr_addr_o,      // Write offset
  output logic [15:0] wr_data_o      // Write data
);
  initial begin
    wr_en_o = 1'b0;
    wr_addr_o = 8'h00;
    wr_data_o = 16'h0000;
  end
  // Released data shows the inverse so stale values never match
  task automatic put(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_en_o <= 1'b1;
    wr_addr_o <= a;
    wr_data_o <= d;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
    wr_data_o <= ~d;
  endtask
  // Request bit held high for n+2 cycles, then withdrawn
  task automatic hold_clear(input int n);
    put(zone_cmd_pkg::OFF_FAULT_RST, 16'h0001);
    repeat (n) @(posedge clk_i);
    put(zone_cmd_pkg::OFF_FAULT_RST, 16'h0000);
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the zone command register block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import zone_cmd_pkg::*;
  localparam int unsigned HC = 20;
  localparam logic [7:0] OFFS [11] = '{OFF_FAULT_RST, OFF_AUX, OFF_UP_REL,
    OFF_UP_STAT, OFF_FWD1, OFF_FWD2, OFF_DN_REL, OFF_DN_STAT, OFF_REV1,
    OFF_REV2, 8'h20};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] rd_addr_i = 8'h00;
  logic rev_dir_i = 1'b0;
  logic [1:0] short_fault_i = 2'b00;
  logic [1:0] sensor_fault_i = 2'b00;
  logic [1:0] aux_unassigned_i = 2'b00;
  wire logic [1:0] aux_pin_i;
  wire logic wr_en;
  wire logic [7:0] wr_addr;
  wire logic [15:0] wr_data;
  logic [15:0] rd_data_o, up_track_w1_o, up_track_w2_o, v;
  logic [1:0] aux_pin_o, aux_pin_oe_n_o, aux_level_o, motor_fault_o;
  logic up_release_o, dn_release_o, up_run_accept_o, up_track_valid_o;
  logic dn_hold_o, dn_release_ok_o, fault_reset_o;
  int err_total = 0;
  int tests_run = 0;
  int rel_n [2] = '{0, 0};
  int fr_n = 0;
  always #5 clk_i = ~clk_i;
  // Pin resolves to the external source (left high) when not driven
  assign aux_pin_i = (~aux_pin_oe_n_o & aux_pin_o) | (aux_pin_oe_n_o & 2'b01);
  plc_model i_plc_model (.clk_i(clk_i), .wr_en_o(wr_en),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data));
  zone_cmd_regs #(.HOLD_CYCLES(HC)) i_zone_cmd_regs (.clk_i(clk_i),
    .rst_i(rst_i), .wr_en_i(wr_en), .wr_addr_i(wr_addr),
    .wr_data_i(wr_data), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
    .rev_dir_i(rev_dir_i), .short_fault_i(short_fault_i),
    .sensor_fault_i(sensor_fault_i), .aux_unassigned_i(aux_unassigned_i),
    .aux_pin_i(aux_pin_i), .aux_pin_o(aux_pin_o),
    .aux_pin_oe_n_o(aux_pin_oe_n_o), .aux_level_o(aux_level_o),
    .up_release_o(up_release_o), .dn_release_o(dn_release_o),
    .up_run_accept_o(up_run_accept_o), .up_track_valid_o(up_track_valid_o),
    .up_track_w1_o(up_track_w1_o), .up_track_w2_o(up_track_w2_o),
    .dn_hold_o(dn_hold_o), .dn_release_ok_o(dn_release_ok_o),
    .motor_fault_o(motor_fault_o), .fault_reset_o(fault_reset_o));
  always @(posedge clk_i) begin
    if (up_release_o === 1'b1) rel_n[0]++;
    if (dn_release_o === 1'b1) rel_n[1]++;
    if (fault_reset_o === 1'b1) fr_n++;
  end
  task automatic give_verdict;
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i) rd_addr_i <= a;
    @(posedge clk_i);
    #1 d = rd_data_o;
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic pulse(input logic [1:0] s, input logic [1:0] r);
    @(posedge clk_i);
    short_fault_i <= s;
    sensor_fault_i <= r;
    @(posedge clk_i);
    short_fault_i <= 2'b00;
    sensor_fault_i <= 2'b00;
    settle();
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    chk({14'h0, aux_pin_oe_n_o}, 16'h0003);
    // Released left pin is pulled high and shows in aux read-back bit 0
    foreach (OFFS[i]) begin
      rd(OFFS[i], v);
      chk(v, (OFFS[i] == OFF_AUX) ? 16'h0001 : REG_RST);
    end
    i_plc_model.put(8'h20, 16'hFFFF);
    rd(8'h20, v);
    chk(v, 16'h0000);
    for (int z = 0; z < 2; z++) begin
      i_plc_model.put(z ? OFF_DN_REL : OFF_UP_REL, 16'h0005);
      settle();
      chk(16'(rel_n[z]), 16'h0000);
      i_plc_model.put(z ? OFF_DN_ACC : OFF_UP_ACC, 16'h0001);
      i_plc_model.put(z ? OFF_DN_REL : OFF_UP_REL, 16'h0006);
      settle();
      chk(16'(rel_n[z]), 16'h0001);
      i_plc_model.put(z ? OFF_DN_REL : OFF_UP_REL, 16'h0006);
      settle();
      chk(16'(rel_n[z]), 16'h0001);
      i_plc_model.put(z ? OFF_DN_REL : OFF_UP_REL, 16'h0007);
      i_plc_model.put(z ? OFF_DN_REL : OFF_UP_REL, 16'h0008);
      settle();
      chk(16'(rel_n[z]), 16'h0003);
      rd(z ? OFF_DN_REL : OFF_UP_REL, v);
      chk(v, 16'h0008);
    end
    i_plc_model.put(OFF_FWD1, 16'h1234);
    i_plc_model.put(OFF_FWD2, 16'h5678);
    i_plc_model.put(OFF_REV1, 16'h9ABC);
    i_plc_model.put(OFF_REV2, 16'hDEF0);
    i_plc_model.put(OFF_UP_STAT, UP_STAT_ACCEPT);
    settle();
    chk({14'h0, up_run_accept_o, up_track_valid_o}, 16'h0002);
    i_plc_model.put(OFF_UP_STAT, UP_STAT_TRACK);
    settle();
    chk({14'h0, up_run_accept_o, up_track_valid_o}, 16'h0001);
    chk(up_track_w1_o, 16'h1234);
    chk(up_track_w2_o, 16'h5678);
    @(posedge clk_i) rev_dir_i <= 1'b1;
    settle();
    chk(up_track_w1_o, 16'h9ABC);
    chk(up_track_w2_o, 16'hDEF0);
    rd(OFF_REV2, v);
    chk(v, 16'hDEF0);
    i_plc_model.put(OFF_DN_STAT, DN_STAT_HOLD);
    settle();
    chk({14'h0, dn_hold_o, dn_release_ok_o}, 16'h0002);
    i_plc_model.put(OFF_DN_STAT, DN_STAT_RELEASE);
    settle();
    chk({14'h0, dn_hold_o, dn_release_ok_o}, 16'h0001);
    pulse(2'b01, 2'b00);
    chk({14'h0, motor_fault_o}, 16'h0001);
    pulse(2'b00, 2'b10);
    chk({14'h0, motor_fault_o}, 16'h0003);
    rd(OFF_FAULT_RST, v);
    chk(v, 16'h0300);
    // A hold shorter than the qualifying time must not clear anything
    i_plc_model.hold_clear(5);
    settle();
    chk({14'h0, motor_fault_o}, 16'h0003);
    chk(16'(fr_n), 16'h0000);
    i_plc_model.hold_clear(HC + 10);
    settle();
    chk(16'(fr_n), 16'h0001);
    chk({14'h0, motor_fault_o}, 16'h0000);
    @(posedge clk_i) aux_unassigned_i <= 2'b11;
    i_plc_model.put(OFF_AUX, 16'h1100);
    settle();
    chk({14'h0, aux_pin_oe_n_o}, 16'h0002);
    chk({14'h0, aux_pin_o}, 16'h0001);
    i_plc_model.put(OFF_AUX, 16'hE2FC);
    settle();
    chk({14'h0, aux_pin_oe_n_o}, 16'h0001);
    chk({14'h0, aux_pin_o}, 16'h0002);
    rd(OFF_AUX, v);
    chk(v, 16'hE2FF);
    chk({14'h0, aux_level_o}, 16'h0003);
    @(posedge clk_i) aux_unassigned_i <= 2'b01;
    settle();
    chk({14'h0, aux_pin_oe_n_o}, 16'h0003);
    give_verdict();
  end
endmodule
`default_nettype wire

// [tb/zone_cmd_properties.sv]
// Port assertions for the zone command register block
`timescale 1ns/1ns
`default_nettype none
module zone_cmd_props
  import zone_cmd_pkg::*;
#(parameter int unsigned HOLD_CYCLES = 20) (
  input wire logic clk_i,            // Clock
  input wire logic rst_i,            // Reset
  input wire logic wr_en_i,          // Write strobe
  input wire logic [7:0] wr_addr_i,  // Write offset
  input wire logic [15:0] wr_data_i, // Write data
  input wire logic [1:0] short_fault_i, // Short fault
  input wire logic [1:0] sensor_fault_i, // Sensor fault
  input wire logic [1:0] aux_unassigned_i, // Aux usage none
  input wire logic [1:0] aux_pin_o,  // Aux drive
  input wire logic [1:0] aux_pin_oe_n_o, // Aux enable
  input wire logic up_release_o,     // Up release
  input wire logic dn_release_o,     // Down release
  input wire logic up_run_accept_o,  // Run to accept
  input wire logic up_track_valid_o, // Tracking load
  input wire logic dn_hold_o,        // Down hold
  input wire logic dn_release_ok_o,  // Down may release
  input wire logic [1:0] motor_fault_o, // Latched fault
  input wire logic fault_reset_o     // Reset accepted
);
  logic [15:0] mem_q [256];
  logic [31:0] hold_q;
  logic up_evt, dn_evt;
  logic [1:0] flt;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      foreach (mem_q[i]) mem_q[i] <= REG_RST;
    end else if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !mem_q[OFF_FAULT_RST][FAULT_RST_BIT]) begin
      hold_q <= 32'h0;
    end else begin
      hold_q <= hold_q + 32'h1;
    end
  end
  assign flt = short_fault_i | sensor_fault_i;
  assign up_evt = wr_en_i && wr_addr_i == OFF_UP_REL &&
    wr_data_i != mem_q[OFF_UP_REL] && mem_q[OFF_UP_ACC][ACC_MODE_BIT];
  assign dn_evt = wr_en_i && wr_addr_i == OFF_DN_REL &&
    wr_data_i != mem_q[OFF_DN_REL] && mem_q[OFF_DN_ACC][ACC_MODE_BIT];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_up_rel; up_release_o == $past(up_evt, 2); endproperty
  a_up_rel: assert property (p_up_rel)
    else $error("upstream release pulse wrong");
  property p_dn_rel; dn_release_o == $past(dn_evt, 2); endproperty
  a_dn_rel: assert property (p_dn_rel)
    else $error("downstream release pulse wrong");
  property p_accept;
    up_run_accept_o == ($past(mem_q[OFF_UP_STAT]) == UP_STAT_ACCEPT);
  endproperty
  a_accept: assert property (p_accept)
    else $error("run to accept wrong");
  property p_track;
    up_track_valid_o == ($past(mem_q[OFF_UP_STAT]) == UP_STAT_TRACK);
  endproperty
  a_track: assert property (p_track)
    else $error("tracking load wrong");
  property p_dn_hold;
    dn_hold_o == ($past(mem_q[OFF_DN_STAT]) == DN_STAT_HOLD);
  endproperty
  a_dn_hold: assert property (p_dn_hold)
    else $error("downstream hold wrong");
  property p_dn_ok;
    dn_release_ok_o == ($past(mem_q[OFF_DN_STAT]) == DN_STAT_RELEASE);
  endproperty
  a_dn_ok: assert property (p_dn_ok)
    else $error("downstream permit wrong");
  property p_latch;
    flt != 2'b00 |=> (motor_fault_o & $past(flt)) == $past(flt);
  endproperty
  a_latch: assert property (p_latch)
    else $error("fault not latched");
  property p_clear;
    fault_reset_o |-> (motor_fault_o & ~$past(flt)) == 2'b00;
  endproperty
  a_clear: assert property (p_clear)
    else $error("fault not cleared");
  property p_hold_time; fault_reset_o |-> hold_q >= HOLD_CYCLES; endproperty
  a_hold_time: assert property (p_hold_time)
    else $error("reset accepted too early");
  property p_aux_lvl;
    !aux_pin_oe_n_o[0] |-> $past(mem_q[OFF_AUX][AUX_L_DIR_BIT]) &&
      aux_pin_o[0] == $past(mem_q[OFF_AUX][AUX_L_LVL_BIT]);
  endproperty
  a_aux_lvl: assert property (p_aux_lvl)
    else $error("left aux drive wrong");
  property p_aux_off; aux_pin_oe_n_o[1] |-> !aux_pin_o[1]; endproperty
  a_aux_off: assert property (p_aux_off)
    else $error("right aux drives while input");
  property p_aux_deny;
    (~$past(aux_unassigned_i) & ~aux_pin_oe_n_o) == 2'b00;
  endproperty
  a_aux_deny: assert property (p_aux_deny)
    else $error("aux driven while pin has another usage");
  c_rel: cover property (up_release_o);
  c_rst: cover property (fault_reset_o);
  c_aux: cover property (!aux_pin_oe_n_o[0]);
endmodule
bind zone_cmd_regs zone_cmd_props #(.HOLD_CYCLES(HOLD_CYCLES)) i_props (
  .clk_i, .rst_i, .wr_en_i, .wr_addr_i, .wr_data_i, .short_fault_i,
  .sensor_fault_i, .aux_unassigned_i, .aux_pin_o, .aux_pin_oe_n_o,
  .up_release_o,
  .dn_release_o, .up_run_accept_o, .up_track_valid_o, .dn_hold_o,
  .dn_release_ok_o, .motor_fault_o, .fault_reset_o);
`default_nettype wire
